// file: hdl/ebt_defines.svh
// Offsets, field positions, reset values and divider settings of the timer pair
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH

// ==========================================================
// Register map (word offsets within a channel, byte stride between channels, one word each)
`define EBT_ADDR_W        8
`define EBT_CH_STRIDE     8'h10
`define EBT_OFF_CLK_SEL   2'h0
`define EBT_OFF_MODE      2'h1
`define EBT_OFF_COMPARE   2'h2
`define EBT_OFF_COUNTER   2'h3
`define EBT_NUM_CH        2

// ==========================================================
// Field positions
`define EBT_CSEL_LSB      0
`define EBT_CSEL_MSB      2
`define EBT_MODE_ENABLE   7
`define EBT_MODE_PWM      6
`define EBT_MODE_SET      3
`define EBT_MODE_CLR      2
`define EBT_MODE_INV      1
`define EBT_MODE_OE       0
`define EBT_MODE_RD_MASK  8'hc3
`define EBT_MODE_WR_MASK  8'hcf

// ==========================================================
// Reset values
`define EBT_CLK_SEL_RST   8'h00
`define EBT_MODE_RST      8'h04
`define EBT_COMPARE_RST   8'h00

// ==========================================================
// Clock selection codes and divider exponents per channel
`define EBT_CSEL_FALL     3'h0
`define EBT_CSEL_RISE     3'h1
`define EBT_DIV_CH0       {4'hb, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3}
`define EBT_DIV_CH1       {4'hc, 4'ha, 4'h8, 4'h7, 4'h6, 4'h4}
`define EBT_PRESCALE_W    12

// ==========================================================
// Bus responses
`define EBT_RESP_OKAY     2'h0
`define EBT_RESP_SLVERR   2'h2

`endif

// file: hdl/ebt_pkg.sv
// Types shared by the timer pair
package ebt_pkg;
   typedef enum logic [1:0] {
      EBT_FF_KEEP,
      EBT_FF_CLEAR,
      EBT_FF_SET,
      EBT_FF_BAD
   } ebt_ffcmd_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic        tick;
   } ebt_pre_state_t;

   typedef struct packed {
      logic [7:0] count;
      logic       ff;
      logic       pwm_active;
      logic       pin_prev;
      logic       pending;
      logic       irq;
      logic       pin_out;
      logic       pin_oe;
   } ebt_ch_state_t;
endpackage

// file: hdl/ebt_prescaler.sv
// Divider of the system clock giving one count pulse per selected period
`timescale 1ns/1ps
`include "ebt_defines.svh"

module ebt_prescaler
   import ebt_pkg::*;
#(
   parameter logic [23:0] DIV_EXP = `EBT_DIV_CH0
)(
   input  wire logic       aclk,     // System clock
   input  wire logic       aresetn,  // Sync reset, active low
   input  wire logic       run,      // Counting enabled
   input  wire logic [2:0] clk_sel,  // Clock selection code
   output logic            tick      // One-cycle count pulse
);
   ebt_pre_state_t st, next_st;
   logic [11:0]    mask;
   logic [3:0]     exp_sel;

   // ==========================================================
   // Division select
   always_comb begin
      exp_sel = 4'h0;
      mask    = 12'h000;
      if (clk_sel >= 3'h2) begin
         exp_sel = DIV_EXP[4*(clk_sel - 3'h2) +: 4];
         mask    = 12'(({1'b0, 12'hfff} >> (5'd12 - {1'b0, exp_sel})));
      end
   end

   // ==========================================================
   // Divider, cleared while stopped so the first pulse is a full period late at most
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!run) begin
         next_st.cnt = 12'h000;
      end else begin
         next_st.cnt = st.cnt + 12'h001;
         if (clk_sel >= 3'h2 && (st.cnt & mask) == mask) begin
            next_st.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule // ebt_prescaler

// file: hdl/ebt_channel.sv
// One 8-bit timer/event counter with compare, output flip-flop and PWM
`timescale 1ns/1ps
`include "ebt_defines.svh"

module ebt_channel
   import ebt_pkg::*;
(
   input  wire logic       aclk,       // System clock
   input  wire logic       aresetn,    // Sync reset, active low
   input  wire logic [2:0] clk_sel,    // Clock selection code
   input  wire logic [7:0] mode,       // Mode control bits
   input  wire logic [7:0] compare,    // Compare value
   input  wire logic       ff_wr,      // Output flip-flop command strobe
   input  wire logic [1:0] ff_cmd,     // {set, clear}
   input  wire logic       rd_hold,    // Counter being read
   input  wire logic       pre_tick,   // Divided clock pulse
   input  wire logic       pin_in,     // Timer pin level
   output logic            pin_out,    // Timer pin drive level
   output logic            pin_oe,     // Timer pin drive enable
   output logic [7:0]      count,      // Up-counter value
   output logic            match_irq   // Match pulse
);
   ebt_ch_state_t st, next_st;
   logic          en;
   logic          pwm;
   logic          inv;
   logic          edge_tick;
   logic          tick;
   logic [7:0]    cnt_inc;

   // ==========================================================
   // Count source
   always_comb begin
      en  = mode[`EBT_MODE_ENABLE];
      pwm = mode[`EBT_MODE_PWM];
      inv = mode[`EBT_MODE_INV];
      edge_tick = 1'b0;
      if (clk_sel == `EBT_CSEL_FALL) begin
         edge_tick = st.pin_prev & ~pin_in;
      end else if (clk_sel == `EBT_CSEL_RISE) begin
         edge_tick = ~st.pin_prev & pin_in;
      end
      tick    = (edge_tick | pre_tick | st.pending) & ~rd_hold;
      cnt_inc = st.count + 8'h01;
   end

   // ==========================================================
   // Counter, compare and output
   always_comb begin
      next_st = st;
      next_st.pin_prev = pin_in;
      next_st.irq      = 1'b0;
      // A pulse during a counter read is deferred, not lost
      if (rd_hold && (edge_tick | pre_tick)) begin
         next_st.pending = 1'b1;
      end else if (tick) begin
         next_st.pending = 1'b0;
      end
      if (!en) begin
         next_st.count      = 8'h00;
         next_st.pending    = 1'b0;
         next_st.pwm_active = 1'b0;
      end else if (tick) begin
         if (pwm) begin
            next_st.count = cnt_inc;
            if (cnt_inc == compare) begin
               next_st.pwm_active = 1'b0;
            end else if (cnt_inc == 8'h00) begin
               next_st.pwm_active = 1'b1;
            end
         end else if (st.count == compare) begin
            next_st.count = 8'h00;
            next_st.irq   = 1'b1;
            if (inv) begin
               next_st.ff = ~st.ff;
            end
         end else begin
            // Wraps past 255 when compare was lowered below the count
            next_st.count = cnt_inc;
         end
      end
      if (ff_wr) begin
         case (ebt_ffcmd_t'(ff_cmd))
            EBT_FF_CLEAR: next_st.ff = 1'b0;
            EBT_FF_SET:   next_st.ff = 1'b1;
            default:      next_st.ff = next_st.ff;
         endcase
      end
      if (pwm) begin
         next_st.pin_out = next_st.pwm_active ^ inv;
      end else begin
         next_st.pin_out = next_st.ff;
      end
      next_st.pin_oe = mode[`EBT_MODE_OE];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pin_out   = st.pin_out;
   assign pin_oe    = st.pin_oe;
   assign count     = st.count;
   assign match_irq = st.irq;
endmodule // ebt_channel

// file: hdl/ebt_timer_pair.sv
// Two 8-bit timer/event counters behind an AXI4-Lite register slave
`timescale 1ns/1ps
`include "ebt_defines.svh"

// Contract
// - Outside PWM, a count equal to compare clears the counter and pulses match.
// - Interval mode repeats match at constant period; clearing enable halts counting.
// - Count clock comes from the low three bits of clock selection.
// - Codes 0 and 1 pick pin falling/rising edge; others divide system clock.
// - Setting enable starts counting selected pulses in the configured mode.
// - Clearing enable zeroes the counter and stops counting and prescaler.
// - Event mode increments once per selected pin edge.
// - With inversion and output on, flip-flop toggles each match for 50% duty.
// - Set/clear bits: 00 keep, 01 force low, 10 force high; 11 not written.
// - Set and clear bits always read back as zero.
// - Mode bit 6 selects free-running PWM instead of clear-on-match.
// - PWM output stays inactive after start until the first overflow.
// - PWM overflow drives active, compare match returns inactive, repeating.
// - PWM active polarity comes from mode bit 1.
// - Bit 1 means inversion enable normally, active-low in PWM mode.
// - Stopping in PWM mode drives the inactive level at once.
// - Mode bit 0 gates the output onto the pin; clear leaves port mode.
// - First match after start may slip by up to one count clock.
// - Compare lowered below count: counter wraps through zero before matching.
// - Reading the counter briefly holds off the count clock.
module ebt_timer_pair
   import ebt_pkg::*;
(
   input  wire logic                    aclk,             // System clock
   input  wire logic                    aresetn,          // Sync reset, active low
   input  wire logic [`EBT_ADDR_W-1:0]  s_axi_awaddr,     // Write address
   input  wire logic [2:0]              s_axi_awprot,     // Write protection, unused
   input  wire logic                    s_axi_awvalid,    // Write address valid
   output logic                         s_axi_awready,    // Write address ready
   input  wire logic [31:0]             s_axi_wdata,      // Write data
   input  wire logic [3:0]              s_axi_wstrb,      // Write byte strobes
   input  wire logic                    s_axi_wvalid,     // Write data valid
   output logic                         s_axi_wready,     // Write data ready
   output logic [1:0]                   s_axi_bresp,      // Write response
   output logic                         s_axi_bvalid,     // Write response valid
   input  wire logic                    s_axi_bready,     // Write response ready
   input  wire logic [`EBT_ADDR_W-1:0]  s_axi_araddr,     // Read address
   input  wire logic [2:0]              s_axi_arprot,     // Read protection, unused
   input  wire logic                    s_axi_arvalid,    // Read address valid
   output logic                         s_axi_arready,    // Read address ready
   output logic [31:0]                  s_axi_rdata,      // Read data
   output logic [1:0]                   s_axi_rresp,      // Read response
   output logic                         s_axi_rvalid,     // Read data valid
   input  wire logic                    s_axi_rready,     // Read data ready
   input  wire logic [1:0]              timer_io_pin_in,  // Timer pin levels
   output logic [1:0]                   timer_io_pin_out, // Timer pin drive levels
   output logic [1:0]                   timer_io_pin_oe,  // Timer pin drive enables
   output logic [1:0]                   match_irq         // Match pulses
);

   // ==========================================================
   // State
   typedef struct packed {
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic                   aw_full;
      logic [`EBT_ADDR_W-1:0] awaddr;
      logic                   w_full;
      logic [7:0]             wdata;
      logic                   wbyte0;
      logic [1:0][7:0]        clk_sel;
      logic [1:0][7:0]        mode;
      logic [1:0][7:0]        compare;
      logic [1:0]             ff_wr;
      logic [1:0][1:0]        ff_cmd;
   } ebt_top_state_t;

   ebt_top_state_t  st, next_st;
   logic [1:0][7:0] count;
   logic [1:0]      pre_tick;
   logic [1:0]      rd_hold;
   logic            ar_take;
   logic            wr_go;

   // ==========================================================
   // Address decode
   function automatic logic reg_mapped(input logic [`EBT_ADDR_W-1:0] a);
      reg_mapped = (a < (`EBT_CH_STRIDE * `EBT_NUM_CH)) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic reg_chan(input logic [`EBT_ADDR_W-1:0] a);
      reg_chan = a[4];
   endfunction

   function automatic logic [1:0] reg_off(input logic [`EBT_ADDR_W-1:0] a);
      reg_off = a[3:2];
   endfunction

   // ==========================================================
   // Bus slave and registers
   always_comb begin
      next_st = st;
      next_st.ff_wr = 2'b00;
      ar_take = s_axi_arvalid & st.arready;
      wr_go   = st.aw_full & st.w_full & ~st.bvalid;
      rd_hold = 2'b00;

      // Write address and data are taken in either order
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_full = 1'b1;
         next_st.awaddr  = s_axi_awaddr;
         next_st.awready = 1'b0;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_full = 1'b1;
         next_st.wdata  = s_axi_wdata[7:0];
         next_st.wbyte0 = s_axi_wstrb[0];
         next_st.wready = 1'b0;
      end

      if (wr_go) begin
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = `EBT_RESP_OKAY;
         if (!reg_mapped(st.awaddr)) begin
            next_st.bresp = `EBT_RESP_SLVERR;
         end else if (st.wbyte0) begin
            case (reg_off(st.awaddr))
               `EBT_OFF_CLK_SEL: begin
                  next_st.clk_sel[reg_chan(st.awaddr)] = {5'h00, st.wdata[2:0]};
               end
               `EBT_OFF_MODE: begin
                  next_st.mode[reg_chan(st.awaddr)] = st.wdata & `EBT_MODE_WR_MASK;
                  next_st.ff_wr[reg_chan(st.awaddr)] = 1'b1;
                  next_st.ff_cmd[reg_chan(st.awaddr)] =
                     {st.wdata[`EBT_MODE_SET], st.wdata[`EBT_MODE_CLR]};
               end
               `EBT_OFF_COMPARE: begin
                  // Takes effect at once, also mid-cycle in PWM mode
                  next_st.compare[reg_chan(st.awaddr)] = st.wdata;
               end
               default: begin
                  next_st.bresp = `EBT_RESP_OKAY;
               end
            endcase
         end
      end

      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end

      if (ar_take) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = `EBT_RESP_OKAY;
         next_st.rdata   = 32'h0000_0000;
         if (!reg_mapped(s_axi_araddr)) begin
            next_st.rresp = `EBT_RESP_SLVERR;
         end else begin
            case (reg_off(s_axi_araddr))
               `EBT_OFF_CLK_SEL: begin
                  next_st.rdata[7:0] = st.clk_sel[reg_chan(s_axi_araddr)];
               end
               `EBT_OFF_MODE: begin
                  next_st.rdata[7:0] =
                     st.mode[reg_chan(s_axi_araddr)] & `EBT_MODE_RD_MASK;
               end
               `EBT_OFF_COMPARE: begin
                  next_st.rdata[7:0] = st.compare[reg_chan(s_axi_araddr)];
               end
               default: begin
                  next_st.rdata[7:0] = count[reg_chan(s_axi_araddr)];
                  rd_hold[reg_chan(s_axi_araddr)] = 1'b1;
               end
            endcase
         end
      end

      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st         <= '0;
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
         st.clk_sel <= {`EBT_CLK_SEL_RST, `EBT_CLK_SEL_RST};
         st.mode    <= {`EBT_MODE_RST, `EBT_MODE_RST};
         st.compare <= {`EBT_COMPARE_RST, `EBT_COMPARE_RST};
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

   // ==========================================================
   // Counter channels
   // The two channels differ only in their divider ladders
   generate
      for (genvar ch = 0; ch < `EBT_NUM_CH; ch++) begin : g_ch
         ebt_prescaler #(
            .DIV_EXP (ch == 0 ? `EBT_DIV_CH0 : `EBT_DIV_CH1)
         ) u_pre (
            .aclk    (aclk),
            .aresetn (aresetn),
            .run     (st.mode[ch][`EBT_MODE_ENABLE]),
            .clk_sel (st.clk_sel[ch][2:0]),
            .tick    (pre_tick[ch])
         );

         ebt_channel u_ch (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .clk_sel   (st.clk_sel[ch][2:0]),
            .mode      (st.mode[ch]),
            .compare   (st.compare[ch]),
            .ff_wr     (st.ff_wr[ch]),
            .ff_cmd    (st.ff_cmd[ch]),
            .rd_hold   (rd_hold[ch]),
            .pre_tick  (pre_tick[ch]),
            .pin_in    (timer_io_pin_in[ch]),
            .pin_out   (timer_io_pin_out[ch]),
            .pin_oe    (timer_io_pin_oe[ch]),
            .count     (count[ch]),
            .match_irq (match_irq[ch])
         );
      end
   endgenerate
endmodule // ebt_timer_pair

// file: verification/ebt_timer_pair_sva.sv
// Checker for the bus handshakes and match pulses of the timer pair
`timescale 1ns/1ps
`include "ebt_defines.svh"
module ebt_sva (
   input wire logic                   aclk,          // Clock
   input wire logic                   aresetn,       // Reset
   input wire logic                   s_axi_awready, // Bus
   input wire logic                   s_axi_wready,  // Bus
   input wire logic                   s_axi_bvalid,  // Bus
   input wire logic                   s_axi_bready,  // Bus
   input wire logic [`EBT_ADDR_W-1:0] s_axi_araddr,  // Bus
   input wire logic                   s_axi_arvalid, // Bus
   input wire logic                   s_axi_arready, // Bus
   input wire logic [31:0]            s_axi_rdata,   // Bus
   input wire logic [1:0]             s_axi_rresp,   // Bus
   input wire logic                   s_axi_rvalid,  // Bus
   input wire logic                   s_axi_rready,  // Bus
   input wire logic [1:0]             match_irq      // Match pulses
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write response not closed");
   AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read response not closed");
   AST_MODE_WO: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == 4'h4
      |=> s_axi_rdata[5:2] == 4'h0) else $error("write-only bits read back");
   AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad unmapped read");
   // Fastest count source gives 8 cycles; one deferred pulse may cost one
   AST_IRQ0_GAP: assert property (match_irq[0] |=> !match_irq[0] [*6])
      else $error("match pulses too close");
   AST_IRQ1_GAP: assert property (match_irq[1] |=> !match_irq[1] [*6])
      else $error("match pulses too close");
endmodule // ebt_sva
bind ebt_timer_pair ebt_sva i_sva (.*);

// file: verification/ebt_pin_src.sv
// External pulse source on the timer pins, yielding to the timer drive
`timescale 1ns/1ps
module ebt_pin_src (
   input  wire logic       aclk, // Clock
   input  wire logic [1:0] run,  // Pulse train on per pin
   input  wire logic [1:0] dout, // Timer drive levels
   input  wire logic [1:0] doe,  // Timer drive enables
   output logic      [1:0] pin   // Resolved pin levels
);
   logic [1:0] src = 2'h0;
   logic [2:0] cnt = 3'h0;
   // Slow edges, so a read hold-off cannot merge two of them
   always @(posedge aclk) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7)
         src <= src ^ run;
   end
   assign pin = (doe & dout) | (~doe & src);
endmodule // ebt_pin_src

// file: verification/tb_ebt_timer_pair.sv
// Self-checking bench for the timer pair
`timescale 1ns/1ps
module tb_ebt_timer_pair import ebt_pkg::*;;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot = 3'h0;
   logic [2:0]  s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, strb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, run;
   logic [1:0]  timer_io_pin_in, timer_io_pin_out, timer_io_pin_oe, match_irq;
   int          failures = 0;
   int          checks_done = 0;
   int          cyc = 0;
   ebt_timer_pair i_dut (.*);
   ebt_pin_src i_src (.aclk(aclk), .run(run), .dout(timer_io_pin_out),
      .doe(timer_io_pin_oe), .pin(timer_io_pin_in));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         failures++;
         results();
      end
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // Register bus
   function automatic logic [7:0] ad(logic c, logic [1:0] off);
      return {3'h0, c, off, 2'h0};
   endfunction
   function automatic logic [1:0] rsp(logic [7:0] a);
      return (a >= 8'h20 || a[1:0] != 2'h0) ? 2'h2 : 2'h0;
   endfunction
   task automatic wr(logic [7:0] a, logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      check("bresp", s_axi_bresp, rsp(a));
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      check("rdata", s_axi_rdata, exp);
      check("rresp", s_axi_rresp, rsp(a));
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // ==========================================================
   // Timer observation
   task automatic period(int c, int exp);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (match_irq[c] !== 1'b1);
      end
      check("irq period", n, exp);
   endtask
   task automatic level_run(logic lv, output int n);
      while (timer_io_pin_out[0] !== lv)
         @(posedge aclk);
      n = 0;
      while (timer_io_pin_out[0] === lv) begin
         @(posedge aclk);
         n++;
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      for (int k = 0; k < 8; k++)
         rd(ad(k[2], k[1:0]), 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h05, 32'h0);
      strb = 4'h0;
      wr(ad(1, 2), 8'h55);
      strb = 4'h1;
      rd(ad(1, 2), 32'h0);
      wr(8'h24, 8'h11);
      check("pin enables", timer_io_pin_oe, 2'h0);
      check("pin levels", timer_io_pin_out, 2'h0);
   endtask
   task automatic t_divide();
      int ex[2][6] = '{'{3, 5, 7, 8, 9, 11}, '{4, 6, 7, 8, 10, 12}};
      for (int c = 0; c < 2; c++)
         for (int s = 2; s < 8; s++) begin
            wr(ad(c, 0), 8'(s));
            wr(ad(c, 2), (s == 2) ? 8'h03 : 8'h00);
            wr(ad(c, 1), 8'h80);
            period(c, ((s == 2) ? 4 : 1) << ex[c][s-2]);
            wr(ad(c, 1), 8'h00);
            rd(ad(c, 3), 32'h0);
         end
   endtask
   task automatic t_event();
      run <= 2'h3;
      for (int c = 0; c < 2; c++) begin
         wr(ad(c, 0), 8'(1 - c));
         wr(ad(c, 2), 8'(c + 1));
         wr(ad(c, 1), 8'h80);
         period(c, 16 * (c + 2));
         wr(ad(c, 1), 8'h00);
      end
      run <= 2'h0;
   endtask
   task automatic t_square();
      int n;
      wr(ad(0, 1), 8'h0b);
      rd(ad(0, 1), 32'h03);
      check("forced high", timer_io_pin_out[0], 1'b1);
      wr(ad(0, 1), 8'h07);
      check("forced low", timer_io_pin_out[0], 1'b0);
      check("output on", timer_io_pin_oe, 2'h1);
      wr(ad(0, 0), 8'h02);
      wr(ad(0, 2), 8'h03);
      wr(ad(0, 1), 8'h83);
      level_run(1'b1, n);
      check("high half", n, 32);
      level_run(1'b0, n);
      check("low half", n, 32);
      wr(ad(0, 1), 8'h02);
      check("port mode", timer_io_pin_oe, 2'h0);
   endtask
   task automatic t_pwm();
      int n;
      wr(ad(0, 2), 8'h40);
      wr(ad(0, 1), 8'hc1);
      check("pwm start", timer_io_pin_out[0], 1'b0);
      // Still inactive well before the first overflow
      repeat (300) @(posedge aclk);
      check("pwm before overflow", timer_io_pin_out[0], 1'b0);
      level_run(1'b1, n);
      check("pwm active", n, 512);
      wr(ad(0, 1), 8'hc3);
      level_run(1'b0, n);
      check("pwm active low", n, 512);
      // Stop inside an active phase, so the drop to inactive is visible
      while (timer_io_pin_out[0] !== 1'b0)
         @(posedge aclk);
      wr(ad(0, 1), 8'h43);
      check("pwm stop", timer_io_pin_out[0], 1'b1);
   endtask
   task automatic t_wrap();
      int t0;
      wr(ad(0, 2), 8'h20);
      wr(ad(0, 1), 8'h80);
      while (match_irq[0] !== 1'b1)
         @(posedge aclk);
      t0 = cyc;
      // Lower compare once the count has passed the new value
      repeat (64) @(posedge aclk);
      wr(ad(0, 2), 8'h04);
      while (match_irq[0] !== 1'b1)
         @(posedge aclk);
      check("wrap period", cyc - t0, 261 * 8);
      wr(ad(0, 1), 8'h00);
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'h1;
      strb = 4'h1;
      run = 2'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_divide();
      t_event();
      t_square();
      t_pwm();
      t_wrap();
      results();
   end
endmodule // tb_ebt_timer_pair
